/* File: hdl/fhtc_consts.vh */
// Constants for the floppy host transfer control block
`ifndef FHTC_CONSTS_VH
`define FHTC_CONSTS_VH
`define FHTC_CFG_IDENT_BIT 3
`define FHTC_CFG_ENC_BIT 2
`define FHTC_CFG_SINGLE_BIT 1
`define FHTC_CFG_RESET 8'h02
`define FHTC_FIFO_DEPTH 16
`define FHTC_PH_CMD 2'h0
`define FHTC_PH_EXEC 2'h1
`define FHTC_PH_RESULT 2'h2
`define FHTC_ST_INVALID 8'h80
`define FHTC_ST_ABNORMAL 8'h40
`define FHTC_ST_NORMAL 8'h00
`endif

/* File: hdl/fhtc_fifo.v */
// Parameterised FIFO between host port and disk side
`timescale 1ns/1ps
module fhtc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];
  localparam [AW:0] LAST_CNT = FULL_CNT - 1'b1;
  localparam [AW-1:0] LAST_IDX = LAST_CNT[AW-1:0];
  assign in_ready = (count_ff != FULL_CNT);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];
  assign level = count_ff;
  always @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_IDX) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_IDX) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // fhtc_fifo

/* File: hdl/fhtc_mode_dec.v */
// Compatibility mode decode from the configuration register
`timescale 1ns/1ps
`include "fhtc_consts.vh"
module fhtc_mode_dec (
  input wire [7:0] fdc_config_reg,
  input wire dma_enable_bit,
  output wire dma_allowed,
  output wire may_float,
  output wire tc_active_high,
  output wire dens_active_high,
  output wire burst_mode
);
  wire ident;
  wire enc;
  assign ident = fdc_config_reg[`FHTC_CFG_IDENT_BIT];
  assign enc = fdc_config_reg[`FHTC_CFG_ENC_BIT];
  // Second-style mode ignores the enable bit and always drives
  assign dma_allowed = (ident || !enc) ? dma_enable_bit : 1'b1;
  assign may_float = ident || !enc;
  assign tc_active_high = ident || !enc;
  assign dens_active_high = ident;
  assign burst_mode = !fdc_config_reg[`FHTC_CFG_SINGLE_BIT]; // [RULE_08]
endmodule // fhtc_mode_dec

/* File: hdl/fhtc_top.v */
// Host transfer control of a floppy disk controller
`timescale 1ns/1ps
`include "fhtc_consts.vh"
// Notes on behaviour
// [RULE_01] Mode from identity and encoding bits
// [RULE_02] Identity high: enable honoured, floats, high
// [RULE_03] Encoding only: enable ignored, driven, low
// [RULE_04] Both low: enable honoured, density low
// [RULE_05] DMA request in transfers; ack opens FIFO
// [RULE_06] Verify pseudo reads in byte-mode reads
// [RULE_07] Single drops after ack; burst holds
// [RULE_08] Config bit 1 clear selects burst
// [RULE_09] Command phase after reset, ordered bytes
// [RULE_10] Host writes only when ready, direction out
// [RULE_11] Ready drops per write, rises per parameter
// [RULE_12] FIFO off after reset until configured
// [RULE_13] Threshold is field plus one
// [RULE_14] Polled reads: request at sixteen minus threshold
// [RULE_15] Polled writes: request until full, refill
// [RULE_16] DMA reads: request at level, drop empty
// [RULE_17] DMA writes: drop on acknowledged count
// [RULE_18] DMA controller writes with ack and strobe
// [RULE_19] Early stop finishes sector, abnormal status
// [RULE_20] Host tolerates lingering request after last
// [RULE_21] Interrupt marks result phase; read all
// [RULE_22] After last result: ready, out, not busy
// [RULE_23] Invalid first byte raises interrupt
module fhtc_top #(
  parameter PARAM_BYTES = 2,
  parameter RESULT_BYTES = 7,
  parameter SECTOR_BYTES = 512
) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] fdc_config_reg,
  input wire dma_enable_bit,
  input wire fifo_enable,
  input wire [3:0] fifo_threshold_field,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  input wire cmd_valid,
  input wire cmd_is_read,
  input wire cmd_is_xfer,
  input wire dma_ack_n,
  input wire io_read_n,
  input wire io_write_n,
  input wire terminal_count,
  input wire host_stop,
  input wire disk_valid,
  input wire [7:0] disk_rdata,
  output wire disk_ready,
  input wire disk_take,
  output reg [7:0] disk_wdata,
  output reg disk_wvalid,
  output reg [7:0] host_rdata_ff,
  output reg request_for_master_ff,
  output reg transfer_direction_ff,
  output reg command_busy_ff,
  output reg disk_irq_out_ff,
  output reg disk_irq_oe_n_ff,
  output reg dma_request_out_ff,
  output reg dma_req_oe_n_ff,
  output reg tc_seen_ff,
  output reg density_select_ff,
  output reg [7:0] result_status_ff
);
  // ****************************************
  // Mode decode and FIFO
  // ****************************************
  wire dma_allowed;
  wire may_float;
  wire tc_high;
  wire dens_high;
  wire burst;
  wire [4:0] level;
  wire f_in_ready;
  wire f_out_valid;
  wire [7:0] f_out_data;
  reg [1:0] phase_ff;
  reg [2:0] pcnt_ff;
  reg [2:0] rcnt_ff;
  reg is_read_ff;
  reg fifo_on_ff;
  reg [9:0] sect_ff;
  reg last_ff;
  reg wr_refill_ff;
  reg flush_ff;
  reg rd_arm_ff;
  wire ack;
  wire tc_act;
  wire [4:0] thr;
  wire fifo_in_valid;
  wire fifo_out_ready;
  wire [7:0] fifo_in_data;
  wire dma_path;
  wire host_beat;
  function [4:0] thresh;
    input [3:0] field;
    begin
      thresh = {1'b0, field} + 5'h01; // [RULE_13]
    end
  endfunction
  fhtc_mode_dec u_mode (
    .fdc_config_reg(fdc_config_reg),
    .dma_enable_bit(dma_enable_bit),
    .dma_allowed(dma_allowed),
    .may_float(may_float),
    .tc_active_high(tc_high),
    .dens_active_high(dens_high),
    .burst_mode(burst)
  ); // [RULE_01]
  assign thr = fifo_on_ff ? thresh(fifo_threshold_field) : 5'h0F;
  assign ack = !dma_ack_n;
  // Count polarity follows mode
  assign tc_act = tc_high ? terminal_count : !terminal_count; // [RULE_02]
  assign dma_path = dma_allowed && (phase_ff == `FHTC_PH_EXEC);
  // Ack with the read or write strobe opens the FIFO, no address involved
  assign host_beat = dma_path ? (ack && (is_read_ff ? !io_read_n
    : !io_write_n)) : (is_read_ff ? host_rd : host_wr); // [RULE_05]
  assign fifo_in_valid = (phase_ff == `FHTC_PH_EXEC) &&
    (is_read_ff ? disk_valid : host_beat);
  assign fifo_in_data = is_read_ff ? disk_rdata : host_wdata;
  assign disk_ready = is_read_ff && f_in_ready &&
    (phase_ff == `FHTC_PH_EXEC);
  // Verify cycles: ack alone pops in byte-mode reads
  assign fifo_out_ready = (phase_ff == `FHTC_PH_EXEC) && (is_read_ff ?
    (host_beat || (dma_path && ack && !fifo_on_ff)) : disk_take); // [RULE_06]
  fhtc_fifo #(
    .WIDTH(8),
    .DEPTH(`FHTC_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(flush_ff),
    .in_valid(fifo_in_valid),
    .in_ready(f_in_ready),
    .in_data(fifo_in_data),
    .out_valid(f_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(f_out_data),
    .level(level)
  );
  // ****************************************
  // Service request logic
  // ****************************************
  reg nxt_req;
  always @* begin
    nxt_req = 1'b0;
    if (phase_ff == `FHTC_PH_EXEC) begin
      if (is_read_ff) begin
        // Read: fill level or sector tail
        // Once armed, service stays requested until the FIFO is empty
        nxt_req = ((level >= (5'h10 - thr)) || last_ff || rd_arm_ff) &&
          f_out_valid; // [RULE_14] [RULE_16]
      end else begin
        nxt_req = wr_refill_ff && !last_ff; // [RULE_15] [RULE_17]
      end
    end
  end
  // ****************************************
  // Phase sequencing
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= `FHTC_PH_CMD; // [RULE_09]
      pcnt_ff <= 3'h0;
      rcnt_ff <= 3'h0;
      is_read_ff <= 1'b0;
      fifo_on_ff <= 1'b0;
      sect_ff <= 10'h000;
      last_ff <= 1'b0;
      wr_refill_ff <= 1'b0;
      flush_ff <= 1'b0;
      rd_arm_ff <= 1'b0;
      host_rdata_ff <= 8'h00;
      request_for_master_ff <= 1'b1;
      transfer_direction_ff <= 1'b0;
      command_busy_ff <= 1'b0;
      disk_irq_out_ff <= 1'b0;
      dma_request_out_ff <= 1'b0;
      tc_seen_ff <= 1'b0;
      result_status_ff <= `FHTC_ST_NORMAL;
      disk_wdata <= 8'h00;
      disk_wvalid <= 1'b0;
    end else begin
      flush_ff <= 1'b0;
      disk_wvalid <= !is_read_ff && disk_take && f_out_valid;
      disk_wdata <= f_out_data;
      case (phase_ff)
        `FHTC_PH_CMD: begin
          fifo_on_ff <= 1'b0; // [RULE_12]
          if (host_wr && request_for_master_ff) begin // [RULE_10]
            request_for_master_ff <= 1'b0; // [RULE_11]
            command_busy_ff <= 1'b1;
            if (pcnt_ff == 3'h0 && !cmd_valid) begin
              disk_irq_out_ff <= 1'b1; // [RULE_23]
              result_status_ff <= `FHTC_ST_INVALID;
              phase_ff <= `FHTC_PH_RESULT;
              rcnt_ff <= 3'h0;
            end else if (pcnt_ff == PARAM_BYTES[2:0]) begin
              pcnt_ff <= 3'h0;
              if (cmd_is_xfer) begin
                phase_ff <= `FHTC_PH_EXEC;
                fifo_on_ff <= fifo_enable;
                sect_ff <= 10'h000;
                last_ff <= 1'b0;
                tc_seen_ff <= 1'b0;
                wr_refill_ff <= 1'b1;
                rd_arm_ff <= 1'b0;
                result_status_ff <= `FHTC_ST_NORMAL;
              end else begin
                phase_ff <= `FHTC_PH_RESULT;
                disk_irq_out_ff <= 1'b1;
                // Drop status left over from an earlier command
                result_status_ff <= `FHTC_ST_NORMAL;
              end
            end else begin
              if (pcnt_ff == 3'h0) begin
                is_read_ff <= cmd_is_read;
              end
              pcnt_ff <= pcnt_ff + 3'h1;
            end
          end else if (command_busy_ff && !request_for_master_ff) begin
            request_for_master_ff <= 1'b1; // [RULE_11]
          end
        end
        `FHTC_PH_EXEC: begin
          transfer_direction_ff <= is_read_ff;
          if (host_beat) begin
            sect_ff <= sect_ff + 10'h001;
          end
          if (sect_ff == SECTOR_BYTES[9:0] - 10'h001 && host_beat) begin
            last_ff <= 1'b1;
          end
          if (tc_act && ack) begin
            last_ff <= 1'b1; // [RULE_17]
            tc_seen_ff <= 1'b1;
          end
          if (host_stop) begin
            last_ff <= 1'b1; // [RULE_19]
            result_status_ff <= `FHTC_ST_ABNORMAL;
          end
          if (!f_in_ready) begin
            wr_refill_ff <= 1'b0;
          end else if (level <= thr[4:0] && level != 5'h00 - 5'h00 &&
            !wr_refill_ff && (16 - level) >= thr) begin
            wr_refill_ff <= 1'b1;
          end
          // Polled mode echoes service need on ready and irq
          if (!dma_allowed) begin
            request_for_master_ff <= nxt_req; // [RULE_14] [RULE_15]
            disk_irq_out_ff <= nxt_req;
          end else begin
            request_for_master_ff <= 1'b0;
          end
          rd_arm_ff <= nxt_req; // [RULE_14]
          // After the polled echo, so the result irq wins
          // Read request lingers until FIFO drains; host copes
          if (last_ff && !f_out_valid) begin // [RULE_20]
            phase_ff <= `FHTC_PH_RESULT;
            disk_irq_out_ff <= 1'b1; // [RULE_21]
            rcnt_ff <= 3'h0;
            flush_ff <= 1'b1;
          end
          if (is_read_ff && host_beat) begin
            host_rdata_ff <= f_out_data;
          end
          // Single mode drops after each ack; burst holds
          if (dma_allowed && nxt_req && !(ack && !burst)) begin
            dma_request_out_ff <= !last_ff || is_read_ff; // [RULE_07]
          end else begin
            dma_request_out_ff <= 1'b0; // [RULE_16]
          end
        end
        `FHTC_PH_RESULT: begin
          dma_request_out_ff <= 1'b0;
          request_for_master_ff <= 1'b1;
          transfer_direction_ff <= 1'b1;
          if (host_rd) begin // [RULE_22]
            disk_irq_out_ff <= 1'b0;
            host_rdata_ff <= result_status_ff;
            if (rcnt_ff == RESULT_BYTES[2:0] - 3'h1) begin
              phase_ff <= `FHTC_PH_CMD;
              transfer_direction_ff <= 1'b0;
              command_busy_ff <= 1'b0; // [RULE_22]
              rcnt_ff <= 3'h0;
            end else begin
              rcnt_ff <= rcnt_ff + 3'h1;
            end
          end
        end
        default: begin
          phase_ff <= `FHTC_PH_CMD;
        end
      endcase
    end
  end
  // ****************************************
  // Pin drivers
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      disk_irq_oe_n_ff <= 1'b0;
      dma_req_oe_n_ff <= 1'b0;
      density_select_ff <= 1'b0;
    end else begin
      // Float only in modes that allow it, when disabled
      disk_irq_oe_n_ff <= may_float && !dma_allowed; // [RULE_02] [RULE_04]
      dma_req_oe_n_ff <= may_float && !dma_allowed; // [RULE_03]
      density_select_ff <= dens_high ? 1'b1 : 1'b0; // [RULE_04]
    end
  end
  // Config bit 1 drives burst choice in mode decode [RULE_08]
endmodule // fhtc_top

/* File: verif/fhtc_dma_model.sv */
// DMA controller model answering the transfer request
`timescale 1ns/1ps
module fhtc_dma_model (
  input wire core_clk,
  input wire rst_n,
  input wire dma_request_out_ff,
  input wire to_dev,
  input wire tc_high,
  input wire [3:0] slow,
  input wire [7:0] tc_at,
  output reg dma_ack_n,
  output reg io_read_n,
  output reg io_write_n,
  output reg terminal_count,
  output reg [7:0] acks
);
  reg [3:0] wait_ff;
  initial begin
    dma_ack_n = 1'b1;
    io_read_n = 1'b1;
    io_write_n = 1'b1;
    terminal_count = 1'b0;
    acks = 8'h00;
    wait_ff = 4'h0;
  end
  // Strobes last one cycle, then return to idle high
  always @(negedge core_clk) begin
    if (!rst_n) begin
      acks <= 8'h00;
      wait_ff <= 4'h0;
    end else if (!dma_ack_n) begin
      dma_ack_n <= 1'b1;
      io_write_n <= 1'b1;
      io_read_n <= 1'b1;
      terminal_count <= ~tc_high;
    end else if (dma_request_out_ff) begin
      if (wait_ff < slow) begin
        wait_ff <= wait_ff + 4'h1;
      end else begin
        wait_ff <= 4'h0;
        dma_ack_n <= 1'b0;
        io_write_n <= ~to_dev;
        io_read_n <= to_dev;
        terminal_count <= (acks + 8'h01 == tc_at) ? tc_high : ~tc_high;
        acks <= acks + 8'h01;
      end
    end
  end
endmodule // fhtc_dma_model

/* File: verif/fhtc_properties.sv */
// Checker of the host port behaviour of the transfer control block
`timescale 1ns/1ps
module fhtc_props (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] fdc_config_reg,
  input wire host_wr,
  input wire cmd_valid,
  input wire dma_ack_n,
  input wire request_for_master_ff,
  input wire transfer_direction_ff,
  input wire command_busy_ff,
  input wire disk_irq_out_ff,
  input wire disk_irq_oe_n_ff,
  input wire dma_request_out_ff,
  input wire dma_req_oe_n_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  reset_vals_a: assert property ($rose(rst_n) |-> request_for_master_ff
    && !transfer_direction_ff && !command_busy_ff && !disk_irq_out_ff
    && !dma_request_out_ff) else $error("bad state after reset");
  first_byte_a: assert property (host_wr && cmd_valid
    && request_for_master_ff && !transfer_direction_ff && !command_busy_ff
    |=> !request_for_master_ff && command_busy_ff ##1 request_for_master_ff)
    else $error("ready not cycled after first byte");
  bad_cmd_irq_a: assert property (host_wr && !cmd_valid
    && request_for_master_ff && !transfer_direction_ff && !command_busy_ff
    |-> ##[1:16] disk_irq_out_ff) else $error("no irq on bad command");
  mode_driven_a: assert property (fdc_config_reg[3:2] == 2'b01
    && $past(fdc_config_reg[3:2]) == 2'b01
    |-> !disk_irq_oe_n_ff && !dma_req_oe_n_ff)
    else $error("outputs floated in encoding mode");
  single_drop_a: assert property (fdc_config_reg[1]
    && dma_request_out_ff && !dma_ack_n |-> ##[1:2] !dma_request_out_ff)
    else $error("single request not dropped");
  dir_end_a: assert property ($fell(transfer_direction_ff)
    |-> request_for_master_ff && !command_busy_ff)
    else $error("bad status after last result");
  busy_result_a: assert property (transfer_direction_ff
    |-> command_busy_ff) else $error("busy low while direction in");
  result_irq_a: assert property ($rose(transfer_direction_ff)
    && request_for_master_ff |-> disk_irq_out_ff)
    else $error("result phase without irq");
endmodule // fhtc_props

bind fhtc_top fhtc_props u_props (.core_clk, .rst_n, .fdc_config_reg,
  .host_wr, .cmd_valid, .dma_ack_n, .request_for_master_ff,
  .transfer_direction_ff, .command_busy_ff, .disk_irq_out_ff,
  .disk_irq_oe_n_ff, .dma_request_out_ff, .dma_req_oe_n_ff);

/* File: verif/test_fhtc_top.sv */
// Self-checking bench of the floppy host transfer control block
`timescale 1ns/1ps
module test_fhtc_top;
  reg core_clk = 1'b0, rst_n = 1'b0, dma_enable_bit = 1'b0;
  reg [7:0] fdc_config_reg = 8'h0A, host_wdata = 8'h00, disk_rdata = 8'h00;
  reg fifo_enable = 1'b0, host_wr = 1'b0, host_rd = 1'b0, cmd_valid = 1'b0;
  reg cmd_is_read = 1'b0, cmd_is_xfer = 1'b0, host_stop = 1'b0;
  reg disk_valid = 1'b0, disk_take = 1'b1, to_dev = 1'b1;
  reg [3:0] fifo_threshold_field = 4'h3;
  wire dma_ack_n, io_read_n, io_write_n, terminal_count, disk_ready;
  wire disk_wvalid, request_for_master, dir, busy, irq, irq_oe_n, dma_request_out, drq_oe_n, tc_seen;
  wire density;
  wire [7:0] disk_wdata, host_rdata_ff, result_status_ff, acks;
  integer fails = 0, tests_run = 0, cyc = 0, wv = 0, i, k, n;
  always #2.5 core_clk = ~core_clk;
  fhtc_top #(.SECTOR_BYTES(32)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .fdc_config_reg(fdc_config_reg), .dma_enable_bit(dma_enable_bit),
    .fifo_enable(fifo_enable), .fifo_threshold_field(fifo_threshold_field),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read),
    .cmd_is_xfer(cmd_is_xfer), .dma_ack_n(dma_ack_n),
    .io_read_n(io_read_n), .io_write_n(io_write_n),
    .terminal_count(terminal_count), .host_stop(host_stop),
    .disk_valid(disk_valid), .disk_rdata(disk_rdata),
    .disk_ready(disk_ready), .disk_take(disk_take), .disk_wdata(disk_wdata),
    .disk_wvalid(disk_wvalid), .host_rdata_ff(host_rdata_ff),
    .request_for_master_ff(request_for_master), .transfer_direction_ff(dir),
    .command_busy_ff(busy), .disk_irq_out_ff(irq),
    .disk_irq_oe_n_ff(irq_oe_n), .dma_request_out_ff(dma_request_out),
    .dma_req_oe_n_ff(drq_oe_n), .tc_seen_ff(tc_seen),
    .density_select_ff(density), .result_status_ff(result_status_ff));
  fhtc_dma_model u_dma (.core_clk(core_clk), .rst_n(rst_n),
    .dma_request_out_ff(dma_request_out), .to_dev(to_dev), .tc_high(1'b1),
    .slow(4'h2), .tc_at(8'h05), .dma_ack_n(dma_ack_n),
    .io_read_n(io_read_n), .io_write_n(io_write_n),
    .terminal_count(terminal_count), .acks(acks));
  // ****************************************
  // Access tasks
  // ****************************************
  task report_and_stop;
    begin
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  function pick(input integer s);
    case (s)
      0: pick = request_for_master & ~dir;
      1: pick = request_for_master & dir;
      2: pick = irq;
      3: pick = dma_request_out;
      default: pick = ~dma_request_out;
    endcase
  endfunction
  // Bounded wait; the caller judges the outcome
  task wait_on(input integer s);
    begin
      n = 0;
      while (pick(s) !== 1'b1 && n < 400) begin
        @(negedge core_clk);
        n = n + 1;
      end
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'b0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      chk({request_for_master, dir, busy}, 8'h04);
    end
  endtask
  task wr_byte(input [7:0] d, input v, input x, input r);
    begin
      wait_on(0);
      chk(pick(0), 1'b1);
      host_wdata = d;
      cmd_valid = v;
      cmd_is_xfer = x;
      cmd_is_read = r;
      host_wr = 1'b1;
      @(negedge core_clk);
      host_wr = 1'b0;
      chk(request_for_master, 1'b0);
      @(negedge core_clk);
    end
  endtask
  task rd_byte(input [7:0] exp);
    begin
      wait_on(1);
      chk(pick(1), 1'b1);
      host_rd = 1'b1;
      @(negedge core_clk);
      host_rd = 1'b0;
      chk(host_rdata_ff, exp);
      repeat (2) @(negedge core_clk);
    end
  endtask
  task command(input [7:0] op, input v, input x, input r);
    begin
      wr_byte(op, v, x, r);
      if (v)
        for (i = 0; i < 2; i = i + 1)
          wr_byte(8'h00, 1'b0, x, r);
    end
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  // Counts bytes handed to the disk side
  always @(negedge core_clk) begin
    if (disk_wvalid === 1'b1)
      wv = wv + 1;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    do_reset;
    fdc_config_reg = 8'h06;
    command(8'hFF, 1'b0, 1'b0, 1'b0);
    wait_on(2);
    chk(irq, 1'b1);
    chk({density, irq_oe_n, drq_oe_n}, 8'h00);
    for (k = 0; k < 7; k = k + 1)
      rd_byte(8'h80);
    chk({request_for_master, dir, busy}, 8'h04);
    fdc_config_reg = 8'h0A;
    command(8'h03, 1'b1, 1'b0, 1'b0);
    for (k = 0; k < 7; k = k + 1)
      rd_byte(8'h00);
    chk({request_for_master, dir, busy}, 8'h04);
    chk({density, irq_oe_n, drq_oe_n}, 8'h07);
    fifo_enable = 1'b1;
    command(8'h06, 1'b1, 1'b1, 1'b1);
    for (k = 0; k < 12; k = k + 1) begin
      chk(irq, 1'b0);
      disk_valid = 1'b1;
      disk_rdata = 8'h10 + k;
      n = 0;
      while (disk_ready !== 1'b1 && n < 50) begin
        @(negedge core_clk);
        n = n + 1;
      end
      @(negedge core_clk);
    end
    disk_valid = 1'b0;
    wait_on(2);
    chk(irq, 1'b1);
    for (k = 0; k < 12; k = k + 1)
      rd_byte(8'h10 + k);
    chk(irq, 1'b0);
    host_stop = 1'b1;
    @(negedge core_clk);
    host_stop = 1'b0;
    wait_on(2);
    chk(irq, 1'b1);
    chk(result_status_ff, 8'h40);
    for (k = 0; k < 7; k = k + 1)
      rd_byte(8'h40);
    chk({request_for_master, dir, busy}, 8'h04);
    fdc_config_reg = 8'h02;
    repeat (2) @(negedge core_clk);
    chk({density, irq_oe_n, drq_oe_n}, 8'h03);
    for (k = 0; k < 2; k = k + 1) begin
      fdc_config_reg = k ? 8'h08 : 8'h0A;
      do_reset;
      wv = 0;
      dma_enable_bit = 1'b1;
      command(8'h05, 1'b1, 1'b1, 1'b0);
      wait_on(3);
      chk(dma_request_out, 1'b1);
      chk({density, irq_oe_n, drq_oe_n}, 8'h04);
      n = 0;
      while (dma_ack_n !== 1'b0 && n < 50) begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk(dma_request_out, k ? 8'h01 : 8'h00);
      while (acks < 8'h05 && cyc < 19000)
        @(negedge core_clk);
      wait_on(4);
      chk(dma_request_out, 1'b0);
      repeat (6) @(negedge core_clk);
      chk(acks, 8'h05);
      chk(tc_seen, 1'b1);
      chk(wv, 8'h05);
      chk(irq, 1'b1);
    end
    // Byte mode read: acknowledge alone must empty the FIFO
    fifo_enable = 1'b0;
    do_reset;
    command(8'h06, 1'b1, 1'b1, 1'b1);
    disk_valid = 1'b1;
    @(negedge core_clk);
    disk_valid = 1'b0;
    repeat (12) @(negedge core_clk);
    chk(acks, 8'h01);
    chk(dma_request_out, 1'b0);
    report_and_stop;
  end
endmodule // test_fhtc_top
